// [pact_pkg.sv]
// constants for the delayed convert start trigger
package pact_pkg;
   // register map (plain port, index addressing)
   localparam logic [3:0] ADDR_TRIG_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_TRIG_STAT  = 4'h1;
   // control field positions
   localparam int         CTRL_EN_BIT     = 7;
   localparam int         CTRL_DLY_MSB    = 3;
   localparam int         CTRL_DLY_LSB    = 0;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK    = 8'h8f;
   // delay code 0 gives 4 pulses, each step adds 4
   localparam int         DLY_BASE        = 4;
   localparam int         DLY_STEP        = 4;
   // code 15 needs 64 pulses, so the counter must reach 64
   localparam int         CNT_W           = 7;
endpackage : pact_pkg

// [pact_trigger.sv]
// delayed adc convert start trigger from the low-side pwm output
//
// How it works
// - when enabled, a rising low-side output starts a convert start trigger.
// - a programmable delay separates that rising edge from the trigger.
// - if the low side falls before the delay ends, no trigger issues.
// - control bit 7 enables triggers; zero suppresses them entirely.
// - control bits 3 to 0 select the delay in clock pulses.
// - code zero is four pulses, plus four per code step.
`timescale 1ns/1ps
module pact_trigger (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // low-side pwm output, from pwm logic on sys_clk
   input  wire logic       low_side_out,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // to the adc sequencer
   output logic            convert_start
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } pact_state_e;

   localparam int CNT_W = pact_pkg::CNT_W;
   // longest delay: code 15
   localparam int MAX_TARGET = (15 * pact_pkg::DLY_STEP) + pact_pkg::DLY_BASE;

   // a narrower counter would wrap before the compare and hide the trigger
   if (MAX_TARGET >= (1 << CNT_W)) begin : g_cnt_too_narrow
      $error("delay counter too narrow for the longest delay code");
   end

   logic             ctrl_en_q, ctrl_en_d;
   logic [3:0]       ctrl_dly_q, ctrl_dly_d;
   logic [7:0]       rdata_q, rdata_d;
   logic             ls_q, ls_d;
   pact_state_e      st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             cs_q, cs_d;
   logic [CNT_W-1:0] target;
   logic             rise;

   // registers
   always_comb begin
      ctrl_en_d  = ctrl_en_q;
      ctrl_dly_d = ctrl_dly_q;
      rdata_d    = 8'h00;
      if (reg_wr && reg_addr == pact_pkg::ADDR_TRIG_CTRL) begin
         // reserved bits are dropped so they always read zero
         ctrl_en_d  = reg_wdata[pact_pkg::CTRL_EN_BIT];
         ctrl_dly_d = reg_wdata[pact_pkg::CTRL_DLY_MSB:pact_pkg::CTRL_DLY_LSB];
      end
      if (reg_rd) begin
         unique case (reg_addr)
            pact_pkg::ADDR_TRIG_CTRL: rdata_d = {ctrl_en_q, 3'h0, ctrl_dly_q};
            pact_pkg::ADDR_TRIG_STAT: rdata_d = {6'h00, st_q == ST_WAIT, ls_q};
            default:                  rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_en_q  <= pact_pkg::CTRL_RESET[pact_pkg::CTRL_EN_BIT];
         ctrl_dly_q <= pact_pkg::CTRL_RESET[3:0];
         rdata_q    <= 8'h00;
      end else begin
         ctrl_en_q  <= ctrl_en_d;
         ctrl_dly_q <= ctrl_dly_d;
         rdata_q    <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // delay in pulses: (code+1)*4
   assign target = CNT_W'((int'(ctrl_dly_q) * pact_pkg::DLY_STEP) + pact_pkg::DLY_BASE);
   // low side is same-clock pwm logic, so no synchroniser
   assign rise   = low_side_out && !ls_q;

   always_comb begin
      ls_d  = low_side_out;
      st_d  = st_q;
      cnt_d = cnt_q;
      cs_d  = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (rise && ctrl_en_q) begin
               st_d  = ST_WAIT;
               cnt_d = CNT_W'(1);
            end
         end
         ST_WAIT: begin
            if (!ctrl_en_q || !low_side_out) begin
               st_d = ST_IDLE;
            end else if (cnt_q == target) begin
               cs_d = 1'b1;
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
      endcase
      if (st_q == ST_WAIT && rise && ctrl_en_q) begin
         st_d  = ST_WAIT;
         cnt_d = CNT_W'(1);
         cs_d  = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ls_q  <= 1'b0;
         st_q  <= ST_IDLE;
         cnt_q <= '0;
         cs_q  <= 1'b0;
      end else begin
         ls_q  <= ls_d;
         st_q  <= st_d;
         cnt_q <= cnt_d;
         cs_q  <= cs_d;
      end
   end

   assign convert_start = cs_q;

   a_trig_single_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      convert_start |=> !convert_start)
      else $error("convert start wider than one clock");
   a_trig_needs_enable: assert property (@(posedge sys_clk) disable iff (rst)
      convert_start |-> $past(ctrl_en_q))
      else $error("trigger while disabled");
   a_trig_needs_high: assert property (@(posedge sys_clk) disable iff (rst)
      convert_start |-> $past(low_side_out))
      else $error("trigger after low side fell");
   sequence s_min_delay;
      rise && ctrl_en_q ##1 1'b1 [*3];
   endsequence
   a_trig_min_delay: assert property (@(posedge sys_clk) disable iff (rst)
      s_min_delay |-> !convert_start)
      else $error("trigger earlier than four pulses");
   a_trig_code0_time: assert property (@(posedge sys_clk) disable iff (rst)
      (rise && ctrl_en_q && ctrl_dly_q == 4'h0) ##1 (low_side_out && ctrl_en_q && !rise) [*4]
      |=> convert_start)
      else $error("code zero did not trigger after four pulses");
   a_trig_idle_off: assert property (@(posedge sys_clk) disable iff (rst)
      (st_q == ST_IDLE) |=> !convert_start)
      else $error("trigger without armed delay");
   a_trig_reserved: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == pact_pkg::ADDR_TRIG_CTRL) |=> reg_rdata[6:4] == 3'h0)
      else $error("reserved bits read nonzero");
   // every accepted rising edge starts the count afresh, whatever the state
   a_trig_restart: assert property (@(posedge sys_clk) disable iff (rst)
      (rise && ctrl_en_q) |=> (st_q == ST_WAIT && cnt_q == CNT_W'(1)))
      else $error("new rising edge did not restart count");

   // a pulse only ever leaves the waiting state
   a_trig_from_wait: assert property (@(posedge sys_clk) disable iff (rst)
      convert_start |-> $past(st_q) == ST_WAIT)
      else $error("trigger without a preceding wait");

   // low side dropping mid-wait aborts with no pulse
   a_trig_abort_fall: assert property (@(posedge sys_clk) disable iff (rst)
      (st_q == ST_WAIT && !low_side_out) |=> (!convert_start && st_q == ST_IDLE))
      else $error("falling low side did not abort the wait");

   // disabled means silent on the next cycle
   a_trig_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !ctrl_en_q |=> !convert_start)
      else $error("trigger while enable bit clear");

   // a control write lands on the next edge
   a_ctrl_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && reg_addr == pact_pkg::ADDR_TRIG_CTRL)
      |=> (ctrl_en_q == $past(reg_wdata[pact_pkg::CTRL_EN_BIT])
           && ctrl_dly_q == $past(reg_wdata[pact_pkg::CTRL_DLY_MSB:pact_pkg::CTRL_DLY_LSB])))
      else $error("control write did not land");

   // control readback shows enable and code
   a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == pact_pkg::ADDR_TRIG_CTRL)
      |=> reg_rdata == {$past(ctrl_en_q), 3'h0, $past(ctrl_dly_q)})
      else $error("control readback wrong");

   // status readback shows waiting flag and sampled low side
   a_stat_readback: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == pact_pkg::ADDR_TRIG_STAT)
      |=> reg_rdata == {6'h00, $past(st_q) == ST_WAIT, $past(ls_q)})
      else $error("status readback wrong");

   // unmapped indices read zero
   a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr != pact_pkg::ADDR_TRIG_CTRL && reg_addr != pact_pkg::ADDR_TRIG_STAT)
      |=> reg_rdata == 8'h00)
      else $error("unmapped index read nonzero");

   // read data stands only in the cycle after a read
   a_rdata_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule : pact_trigger

// [pact_adc_model.sv]
// adc sequencer stand-in: counts convert starts
`timescale 1ns/1ps
module pact_adc_model (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic convert_start,
   output int        n_starts
);
   always_ff @(posedge sys_clk) begin
      if (rst) n_starts <= 0;
      else if (convert_start === 1'b1) n_starts <= n_starts + 1;
   end
endmodule : pact_adc_model

// [pwm_adc_convert_trigger_bench.sv]
// register and trigger timing tests for the convert start block
`timescale 1ns/1ps
module pwm_adc_convert_trigger_bench;
   logic       sys_clk = 1'b0, rst = 1'b1, low_side_out = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic       convert_start;
   int         n_starts, n_fail = 0, n_compared = 0;
   int         codes[3] = '{0, 9, 15};
   pact_trigger dut (.sys_clk(sys_clk), .rst(rst), .low_side_out(low_side_out), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .convert_start(convert_start));
   pact_adc_model adc (.sys_clk(sys_clk), .rst(rst), .convert_start(convert_start), .n_starts(n_starts));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   // low side high for w sampled edges; exp is the edge index of the pulse, 0 for none
   task automatic pulse(input int w, input int exp);
      int hit;
      hit = 0;
      @(posedge sys_clk);
      low_side_out <= 1'b1;
      for (int i = 1; i <= w + 4; i++) begin
         @(posedge sys_clk);
         if (i == w) low_side_out <= 1'b0;
         #1 if (convert_start === 1'b1) hit = hit * 256 + i;
      end
      chk(hit[7:0], exp[7:0]);
   endtask : pulse
   task automatic wrap_up;
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      #20000;
      n_fail++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h0, 8'h00);
      rd(4'h5, 8'h00);
      pulse(10, 0);
      foreach (codes[k]) begin
         wr(4'h0, 8'h80 | codes[k][7:0]);
         rd(4'h0, 8'h80 | codes[k][7:0]);
         pulse((codes[k] + 1) * 4 + 2, (codes[k] + 1) * 4 + 1);
      end
      wr(4'h0, 8'h80);
      pulse(3, 0);
      pulse(5, 5);
      wr(4'h0, 8'h09);
      pulse(45, 0);
      chk(n_starts[7:0], 8'h04);
      wrap_up();
   end
endmodule : pwm_adc_convert_trigger_bench
